/* common/abe_consts.vh */
// constants for the and / bit set-clear execution block
`ifndef ABE_CONSTS_VH
`define ABE_CONSTS_VH
`define ABE_OP_LIT_AND    4'hE
`define ABE_OP_FILE_AND   6'h05
`define ABE_OP_BIT_CLEAR  4'h4
`define ABE_OP_BIT_SET    4'h5
`define ABE_OP4_MSB       11
`define ABE_OP4_LSB       8
`define ABE_OP6_LSB       6
`define ABE_DEST_BIT      5
`define ABE_BIT_MSB       7
`define ABE_BIT_LSB       5
`define ABE_ADDR_MSB      4
`define ABE_ADDR_LSB      0
`define ABE_LIT_MSB       7
`define ABE_LIT_LSB       0
`define ABE_ACC_RESET     8'h00
`define ABE_ZERO_RESET    1'b0
`define ABE_WDATA_RESET   8'h00
`define ABE_ADDR_RESET    5'h00
`endif

/* src/abe_bit_mask.v */
// one-hot bit mask from a three-bit index
`timescale 1ns/1ns
module abe_bit_mask (
  // index in, mask out
  input  wire [2:0] bit_index_i,
  output wire [7:0] bit_mask_o
);
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_mask
      // a genvar cannot be part-selected, so compare at full width
      localparam [31:0] IDX = g;
      assign bit_mask_o[g] = ({29'h0000000, bit_index_i} == IDX);
    end
  endgenerate
endmodule // abe_bit_mask

/* src/abe_exec.v */
// decode and execution of literal and, file and, bit clear and bit set
// Functional notes
// [RL1] literal and: acc and literal, zero flag
// [RL2] file and: acc and file, zero flag
// [RL3] file and destination: 0 acc, 1 file
// [RL4] bit clear: indexed bit cleared, flags unchanged
// [RL5] bit set: indexed bit set, flags unchanged
// [RL6] bit ops keep the other seven bits
`timescale 1ns/1ns
`include "abe_consts.vh"
module abe_exec (
  // clock and reset
  input  wire        CLK_I,
  input  wire        RST_B_I,
  // instruction in
  input  wire        INSTR_VALID_I,
  input  wire [11:0] INSTR_I,
  // file read data for the address in INSTR_I bits 4:0
  input  wire [7:0]  FILE_RDATA_I,
  // file register write
  output reg  [4:0]  FILE_ADDR_O,
  output reg  [7:0]  FILE_WDATA_O,
  output reg         FILE_WE_O,
  // accumulator and zero flag
  output reg  [7:0]  ACC_O,
  output reg         ZERO_O,
  output reg         ZERO_WE_O
);
  // read address is combinational so the file answers in the same cycle
  wire [3:0] op4       = INSTR_I[`ABE_OP4_MSB:`ABE_OP4_LSB];
  wire [5:0] op6       = INSTR_I[`ABE_OP4_MSB:`ABE_OP6_LSB];
  wire [7:0] literal   = INSTR_I[`ABE_LIT_MSB:`ABE_LIT_LSB];
  wire [2:0] bit_index = INSTR_I[`ABE_BIT_MSB:`ABE_BIT_LSB];
  wire [4:0] file_addr = INSTR_I[`ABE_ADDR_MSB:`ABE_ADDR_LSB];
  wire       dest_file = INSTR_I[`ABE_DEST_BIT];
  wire [7:0] bit_mask;

  abe_bit_mask u_mask (
    .bit_index_i (bit_index),
    .bit_mask_o  (bit_mask)
  );

  wire is_lit_and = INSTR_VALID_I && (op4 == `ABE_OP_LIT_AND);
  wire is_f_and   = INSTR_VALID_I && (op6 == `ABE_OP_FILE_AND);
  wire is_bclr    = INSTR_VALID_I && (op4 == `ABE_OP_BIT_CLEAR);
  wire is_bset    = INSTR_VALID_I && (op4 == `ABE_OP_BIT_SET);

  wire [7:0] lit_result  = ACC_O & literal;         // [RL1]
  // a pending write lands in the file only at the next edge, after this read;
  // forward it so back-to-back operations on one register see the new byte
  wire       fwd_hit     = FILE_WE_O && (FILE_ADDR_O == file_addr);
  wire [7:0] file_data   = fwd_hit ? FILE_WDATA_O : FILE_RDATA_I;
  wire [7:0] file_result = ACC_O & file_data;       // [RL2]
  // whole byte is read and written back, only the mask bit moves
  wire [7:0] clr_result  = file_data & ~bit_mask;   // [RL4] [RL6]
  wire [7:0] set_result  = file_data | bit_mask;    // [RL5] [RL6]

  reg [7:0] acc_next;
  reg       zero_next;
  reg       zero_we_next;
  reg       file_we_next;
  reg [7:0] file_wdata_next;

  always @* begin
    acc_next        = ACC_O;
    zero_next       = ZERO_O;
    zero_we_next    = 1'b0;
    file_we_next    = 1'b0;
    file_wdata_next = FILE_WDATA_O;
    if (is_lit_and) begin
      acc_next     = lit_result;            // [RL1]
      zero_next    = (lit_result == 8'h00); // [RL1]
      zero_we_next = 1'b1;
    end else if (is_f_and) begin
      zero_next    = (file_result == 8'h00); // [RL2]
      zero_we_next = 1'b1;
      if (dest_file) begin
        file_we_next    = 1'b1;              // [RL3]
        file_wdata_next = file_result;
      end else begin
        acc_next = file_result;              // [RL3]
      end
    end else if (is_bclr) begin
      file_we_next    = 1'b1;                // [RL4]
      file_wdata_next = clr_result;
    end else if (is_bset) begin
      file_we_next    = 1'b1;                // [RL5]
      file_wdata_next = set_result;
    end
  end

  // results are registered, so each write reaches the ports one edge after the decode and lands in the file one edge later
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ACC_O        <= `ABE_ACC_RESET;
      ZERO_O       <= `ABE_ZERO_RESET;
      ZERO_WE_O    <= 1'b0;
      FILE_WE_O    <= 1'b0;
      FILE_WDATA_O <= `ABE_WDATA_RESET;
      FILE_ADDR_O  <= `ABE_ADDR_RESET;
    end else begin
      ACC_O        <= acc_next;
      ZERO_O       <= zero_next;
      ZERO_WE_O    <= zero_we_next;
      FILE_WE_O    <= file_we_next;
      FILE_WDATA_O <= file_wdata_next;
      FILE_ADDR_O  <= file_addr;
    end
  end
endmodule // abe_exec

/* testbench/abe_exec_props.sv */
// assertion checker for the and and bit set-clear execution block
`timescale 1ns/1ns
module abe_exec_props (
  // all ports of the block, watched only
  input wire CLK_I, RST_B_I, INSTR_VALID_I, FILE_WE_O, ZERO_O, ZERO_WE_O,
  input wire [11:0] INSTR_I,
  input wire [7:0]  FILE_RDATA_I, FILE_WDATA_O, ACC_O,
  input wire [4:0]  FILE_ADDR_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  wire [11:0] i = INSTR_I;
  wire [3:0]  o = INSTR_VALID_I ? i[11:8] : 4'h0;
  // the file takes a write at the next edge, so a write in flight is the byte it holds
  wire [7:0]  r = (FILE_WE_O && FILE_ADDR_O == i[4:0]) ? FILE_WDATA_O : FILE_RDATA_I;
  wire [7:0]  m = 8'h01 << i[7:5];
  wire        any_op = o == 4'hE || o == 4'h4 || o == 4'h5 || (o == 4'h1 && i[7:6] == 2'h1);
  AST_LIT: assert property (o == 4'hE |=> ZERO_WE_O && !FILE_WE_O &&
    ACC_O == ($past(ACC_O) & $past(i[7:0]))) else $error("literal and");
  AST_ZERO: assert property (ZERO_WE_O |->
    ZERO_O == ((FILE_WE_O ? FILE_WDATA_O : ACC_O) == 8'h00)) else $error("zero flag");
  AST_FACC: assert property (o == 4'h1 && i[7:5] == 3'h2 |=> ZERO_WE_O &&
    !FILE_WE_O && ACC_O == ($past(ACC_O) & $past(r))) else $error("file and to acc");
  AST_FFILE: assert property (o == 4'h1 && i[7:5] == 3'h3 |=> FILE_WE_O && ZERO_WE_O &&
    $stable(ACC_O) && FILE_WDATA_O == (ACC_O & $past(r))) else $error("file and to file");
  AST_CLR: assert property (o == 4'h4 |=> FILE_WE_O && !ZERO_WE_O &&
    $stable(ZERO_O) && $stable(ACC_O) &&
    FILE_WDATA_O == ($past(r) & ~$past(m))) else $error("bit clear");
  AST_SET: assert property (o == 4'h5 |=> FILE_WE_O && !ZERO_WE_O &&
    $stable(ZERO_O) && $stable(ACC_O) &&
    FILE_WDATA_O == ($past(r) | $past(m))) else $error("bit set");
  AST_ADDR: assert property (FILE_WE_O |->
    FILE_ADDR_O == $past(i[4:0])) else $error("write address");
  AST_IDLE: assert property (!any_op |=> !FILE_WE_O && !ZERO_WE_O &&
    $stable(ACC_O) && $stable(ZERO_O)) else $error("refused instruction acted");
  cover property (o == 4'hE);
  cover property (o == 4'h1 && i[7:5] == 3'h3);
  cover property (o == 4'h4);
  cover property (o == 4'h5);
endmodule // abe_exec_props

/* testbench/abe_exec_tb_top.sv */
// self-checking bench for the and and bit set-clear execution block
`timescale 1ns/1ns
module abe_exec_tb_top;
  reg CLK_I = 0, RST_B_I = 0, v = 0, z = 0, we, zw;
  reg [11:0] ins = 12'h000, nx;
  reg [7:0]  mem [0:31], sh [0:31], acc, rd, res;
  reg [31:0] r = 32'hB4F9;
  wire fwe, zo, zwo;
  wire [7:0] wd, ao;
  wire [4:0] fa;
  integer fails = 0, compares = 0, k;
  always #5 CLK_I = ~CLK_I;
  // file registers: loaded once at start, then written only through the block's own write port, at the edge
  always @(posedge CLK_I) begin
    if (fwe) mem[fa] <= wd;
  end
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  abe_exec abe_exec_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .INSTR_VALID_I(v), .INSTR_I(ins),
    .FILE_RDATA_I(mem[ins[4:0]]), .FILE_ADDR_O(fa), .FILE_WDATA_O(wd), .FILE_WE_O(fwe),
    .ACC_O(ao), .ZERO_O(zo), .ZERO_WE_O(zwo));
  task chk(input [15:0] a, input [15:0] e);
    begin
      compares = compares + 1;
      if (a !== e) begin
        fails = fails + 1;
        $display("unexpected at %0t: %h vs %h", $time, a, e);
      end
    end
  endtask
  task summarize;
    begin
      if (fails == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    acc = 8'h00;
    for (k = 0; k < 32; k = k + 1) begin
      mem[k] <= k * 37;
      sh[k] = k * 37;
    end
    repeat (16) @(posedge CLK_I);
    #1 RST_B_I = 1;
    for (k = 0; k < 600; k = k + 1) begin
      // lfsr step; opcode forced often so every kind and its edge fields recur
      r = lfsr_next(r);
      nx = r[11:0];
      case (r[14:12])
        0: nx[11:8] = 4'hE;
        1: nx[11:6] = 6'h05;
        2, 3: nx[11:9] = 3'h2;
      endcase
      ins = nx;
      v = r[17:15] != 0;
      rd = sh[nx[4:0]];
      @(posedge CLK_I);
      #1 zw = v && (ins[11:8] == 4'hE || ins[11:6] == 6'h05);
      we = v && ins[11:9] == 3'h2;
      res = ins[8] ? rd | 8'h01 << ins[7:5] : rd & ~(8'h01 << ins[7:5]);
      if (zw) begin
        res = acc & (ins[11] ? ins[7:0] : rd);
        z = res == 8'h00;
        we = ins[11:5] == 7'h0B;
        if (!we) acc = res;
      end
      if (we) sh[ins[4:0]] = res;
      chk({fa, ao, zo, zwo, fwe}, {ins[4:0], acc, z, zw, we});
      if (we) chk(wd, res);
    end
    // let the last write land, then the file must match the model byte for byte
    v = 0;
    @(posedge CLK_I);
    #1;
    for (k = 0; k < 32; k = k + 1) chk(mem[k], sh[k]);
    summarize;
  end
endmodule // abe_exec_tb_top
bind abe_exec abe_exec_props abe_exec_props_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I), .FILE_RDATA_I(FILE_RDATA_I),
  .FILE_ADDR_O(FILE_ADDR_O), .FILE_WDATA_O(FILE_WDATA_O), .FILE_WE_O(FILE_WE_O),
  .ACC_O(ACC_O), .ZERO_O(ZERO_O), .ZERO_WE_O(ZERO_WE_O));
